// ---- logic/clamp_pwm_timing.v ----
// ramp oscillator, sync, soft start and complementary drive timing
//
// Contract
// - a skipped main pulse also drops the clamp pulse of that cycle
// - main on time never exceeds the ramp charging interval
// - main drive stays off while the ramp discharges
// - sync rising edge ends charging at once and starts discharge
// - discharge reaching valley starts a new charge automatically
// - sync leaves charge and discharge rates unchanged
// - too wide sync pulse pauses ramp flat with both drives off
// - both drives off once discharge ends while sync input stays continuously high
// - charge time is r times 37.33 pF, discharge r times 16 pF
// - soft-start current is 2.5 V over charge resistor times 0.43
// - soft start runs 0 to 5 V, only 1.25 to 4.5 V limits width
// - turn-on delay is 50 ns plus delay resistor over 0.87e11
// - clamp drive is complement of main drive apart from delays
// - switching only above 1.25 V feedback, else pulses skipped
`timescale 1ns/10ps
`include "clamp_pwm_defs.vh"

module clamp_pwm_timing #(
  parameter RW = 24,
  parameter CW = 20
) (
  input wire clk,
  input wire rst_n,
  input wire ext_timebase,
  input wire [7:0] feedback_level,
  input wire [RW-1:0] charge_timing_resistor,
  input wire [RW-1:0] discharge_timing_resistor,
  input wire [RW-1:0] turn_on_delay_resistor,
  input wire [15:0] soft_start_capacitor,
  output reg main_drive,
  output reg clamp_drive,
  output reg ramp_charging,
  output reg [7:0] soft_start_level
);

  localparam ST_CHARGE = 2'd0;
  localparam ST_DISCHARGE = 2'd1;
  localparam ST_PAUSE = 2'd2;

  // ohms to cycles in 16-bit fixed point, rounded to nearest
  // fF times ohms gives fs, hence the extra 1000 against the ps period;
  // 64 bits so the shifted charge factor cannot wrap negative
  localparam [63:0] K_CHARGE_W = ((64'd1 * `CHARGE_FACTOR_FF << `FRAC_BITS)
    + `CLK_PERIOD_PS * 500) / (`CLK_PERIOD_PS * 1000);
  localparam [31:0] K_CHARGE = K_CHARGE_W[31:0];
  localparam [63:0] K_DISCH_W = ((64'd1 * `DISCHARGE_FACTOR_FF << `FRAC_BITS)
    + `CLK_PERIOD_PS * 500) / (`CLK_PERIOD_PS * 1000);
  localparam [31:0] K_DISCH = K_DISCH_W[31:0];
  localparam [31:0] K_DELAY = ((1000 << `FRAC_BITS) / `DELAY_OHM_PER_NS
    + `CLK_PERIOD_PS / 2) / `CLK_PERIOD_PS;
  // soft-start cycles per code = c * r * code_v / (2.5 * 0.43 * tclk)
  // scaled by 2^32 and c in pF
  localparam [63:0] K_SS = (64'd1 << 32) * `SS_CODE_UV * 100
    / (64'd1000 * `SS_VREF_MV * `SS_GAIN_X100 * `CLK_PERIOD_PS);
  // one cycle in the 32.32 soft-start accumulator
  localparam [63:0] SS_STEP = 64'h0000_0001_0000_0000;
  localparam [CW-1:0] DELAY_FIXED = `DELAY_FIXED_CYC;
  localparam [7:0] CTRL_RANGE = `CODE_SS_TOP - `CODE_ZERO_DUTY;

  reg sync_a;
  reg sync_b;
  reg sync_c;
  reg sync_level;
  reg sync_prev;
  reg [1:0] state;
  reg [CW-1:0] count;
  reg [CW-1:0] charge_cyc;
  reg [CW-1:0] disch_cyc;
  reg [CW-1:0] delay_cyc;
  reg [63:0] ss_cyc;
  reg [63:0] ss_count;
  reg cycle_active;
  reg pwm_on;
  reg [CW-1:0] dead_count;

  wire [RW+31:0] charge_prod = charge_timing_resistor * K_CHARGE;
  wire [RW+31:0] disch_prod = discharge_timing_resistor * K_DISCH;
  wire [RW+31:0] delay_prod = turn_on_delay_resistor * K_DELAY;
  wire [RW+79:0] ss_prod = charge_timing_resistor * soft_start_capacitor
    * K_SS;
  wire sync_rise = sync_level & ~sync_prev;
  wire [7:0] ctrl = (feedback_level < soft_start_level) ? feedback_level :
    soft_start_level;
  // soft start above 4.5 V no longer limits width
  wire [7:0] ctrl_lim = (soft_start_level >= `CODE_SS_TOP) ? feedback_level :
    ctrl;
  wire allow = ctrl_lim > `CODE_ZERO_DUTY;
  wire [7:0] ctrl_span = ctrl_lim - `CODE_ZERO_DUTY;
  // width demand compared without a divider: count*range vs span*charge
  wire [CW+7:0] ramp_scaled = count * CTRL_RANGE;
  wire [CW+7:0] demand_scaled = ctrl_span * charge_cyc;
  wire charge_done = (count + 1'b1) >= charge_cyc;
  wire disch_done = (count + 1'b1) >= disch_cyc;

  // three stages; a change counts once the last two agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      sync_level <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_a <= ext_timebase;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (sync_b == sync_c) begin
        sync_level <= sync_c;
      end
      sync_prev <= sync_level;
    end
  end

  // interval lengths from the timing resistors, at least one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_cyc <= {{(CW-1){1'b0}}, 1'b1};
      disch_cyc <= {{(CW-1){1'b0}}, 1'b1};
      delay_cyc <= DELAY_FIXED;
      ss_cyc <= SS_STEP;
    end else begin
      charge_cyc <= (charge_prod[`FRAC_BITS+CW-1:`FRAC_BITS] == 0) ?
        {{(CW-1){1'b0}}, 1'b1} :
        charge_prod[`FRAC_BITS+CW-1:`FRAC_BITS];
      disch_cyc <= (disch_prod[`FRAC_BITS+CW-1:`FRAC_BITS] == 0) ?
        {{(CW-1){1'b0}}, 1'b1} :
        disch_prod[`FRAC_BITS+CW-1:`FRAC_BITS];
      delay_cyc <= delay_prod[`FRAC_BITS+CW-1:`FRAC_BITS]
        + DELAY_FIXED;
      // fraction kept: truncating to whole cycles skews the ramp rate
      ss_cyc <= (ss_prod[63:32] == 32'h0) ? SS_STEP :
        ss_prod[63:0];
    end
  end

  // soft-start ramp, one code per ss_cyc cycles, 0 V up to 5 V
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_count <= 64'h0;
      soft_start_level <= 8'h00;
    end else if (soft_start_level != `CODE_SS_FULL) begin
      if (ss_count + SS_STEP >= ss_cyc) begin
        ss_count <= ss_count + SS_STEP - ss_cyc;
        soft_start_level <= soft_start_level + 8'h01;
      end else begin
        ss_count <= ss_count + SS_STEP;
      end
    end
  end

  // ramp oscillator; sync cuts charging short or holds a pause, rates stay put
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_DISCHARGE;
      count <= {CW{1'b0}};
      cycle_active <= 1'b0;
    end else begin
      case (state)
        ST_CHARGE: begin
          if (sync_rise || charge_done) begin
            state <= ST_DISCHARGE;
            count <= {CW{1'b0}};
          end else begin
            count <= count + 1'b1;
          end
        end
        ST_DISCHARGE: begin
          if (disch_done) begin
            count <= {CW{1'b0}};
            if (sync_level) begin
              state <= ST_PAUSE;
              cycle_active <= 1'b0;
            end else begin
              state <= ST_CHARGE;
              cycle_active <= allow;
            end
          end else begin
            count <= count + 1'b1;
          end
        end
        default: begin
          // flat ramp while sync is held high
          cycle_active <= 1'b0;
          if (!sync_level) begin
            state <= ST_CHARGE;
            count <= {CW{1'b0}};
            cycle_active <= allow;
          end
        end
      endcase
    end
  end

  // pwm request: only within charging, ends on width demand
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_on <= 1'b0;
      ramp_charging <= 1'b0;
    end else begin
      ramp_charging <= (state == ST_CHARGE);
      if (state != ST_CHARGE || sync_rise || charge_done) begin
        pwm_on <= 1'b0;
      end else if (count == {CW{1'b0}}) begin
        pwm_on <= allow;
      end else if (ramp_scaled >= demand_scaled || !allow) begin
        pwm_on <= 1'b0;
      end
    end
  end

  // complementary drives with turn-on delay on both edges
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_drive <= 1'b0;
      clamp_drive <= 1'b0;
      dead_count <= {CW{1'b0}};
    end else if (pwm_on && cycle_active) begin
      clamp_drive <= 1'b0;
      if (clamp_drive) begin
        dead_count <= {CW{1'b0}};
      end else if (dead_count < delay_cyc) begin
        dead_count <= dead_count + 1'b1;
      end else begin
        main_drive <= 1'b1;
      end
    end else begin
      main_drive <= 1'b0;
      if (main_drive) begin
        dead_count <= {CW{1'b0}};
      end else if (!cycle_active || state == ST_PAUSE) begin
        clamp_drive <= 1'b0;
        dead_count <= {CW{1'b0}};
      end else if (dead_count < delay_cyc) begin
        dead_count <= dead_count + 1'b1;
      end else begin
        clamp_drive <= 1'b1;
      end
    end
  end

endmodule // clamp_pwm_timing

// ---- logic/clamp_pwm_defs.vh ----
// timing constants for the active clamp pwm timing block
`ifndef CLAMP_PWM_DEFS_VH
`define CLAMP_PWM_DEFS_VH
// clock period in ps (250 mhz)
`define CLK_PERIOD_PS 4000
// charge interval factor in fF per ohm, discharge factor in fF per ohm
`define CHARGE_FACTOR_FF 37330
`define DISCHARGE_FACTOR_FF 16000
// fixed part of the turn-on delay in ps, resistor part in ohms per ns
`define DELAY_FIXED_PS 50000
`define DELAY_OHM_PER_NS 87
// cycles of the fixed delay, rounded up
`define DELAY_FIXED_CYC ((`DELAY_FIXED_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// control voltages as 8-bit codes, full scale 5 V = 8'hff
`define CODE_ZERO_DUTY 8'h40
`define CODE_SS_TOP 8'he6
`define CODE_SS_FULL 8'hff
// soft-start: iss = 2.5 V * 0.43 / r, step of one code = 5/255 V
`define SS_VREF_MV 2500
`define SS_GAIN_X100 43
`define SS_CODE_UV 19608
// fixed-point scale for resistor to cycle conversions
`define FRAC_BITS 16
`endif

// ---- testbench/clamp_pwm_properties.sv ----
// pin-level assertions for the clamp pwm timing block
`timescale 1ns/10ps
module clamp_pwm_properties (
  input wire clk,
  input wire rst_n,
  input wire ext_timebase,
  input wire [7:0] feedback_level,
  input wire main_drive,
  input wire clamp_drive,
  input wire ramp_charging,
  input wire [7:0] soft_start_level
);
  reg [8:0] hi, lo, sy, fl;
  function [8:0] sat(input [8:0] v, input b);
    sat = b ? v + {8'h0, v != 9'h1ff} : 9'h0;
  endfunction
  // saturating run lengths, long waits exceed unrolled repeats
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi <= 9'h0;
      lo <= 9'h0;
      sy <= 9'h0;
      fl <= 9'h0;
    end else begin
      hi <= sat(hi, ext_timebase);
      lo <= sat(lo, !ramp_charging);
      sy <= sat(sy, !ext_timebase);
      fl <= sat(fl, feedback_level <= 8'h40);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // fixed delay part alone is 13 cycles
  sequence s_gap(s);
    (!s) [*8];
  endsequence
  a_drives_apart: assert property (!(main_drive && clamp_drive))
    else $error("drives overlap");
  a_clamp_gap: assert property ($fell(main_drive)
    |-> s_gap(clamp_drive)) else $error("clamp on too soon");
  a_main_gap: assert property ($fell(clamp_drive)
    |-> s_gap(main_drive)) else $error("main on too soon");
  a_chg_cap: assert property (main_drive |-> ramp_charging)
    else $error("main on outside charge");
  a_sync_ends: assert property ($rose(ext_timebase) && ramp_charging
    |-> ##[1:8] !ramp_charging) else $error("sync did not end charge");
  a_hold_off: assert property (hi >= 9'h40
    |-> !main_drive && !clamp_drive) else $error("drive on with sync held");
  a_valley_go: assert property (!(lo >= 9'h40 && sy >= 9'h40))
    else $error("no new charge");
  a_skip_off: assert property (fl >= 9'h100
    |-> !main_drive && !clamp_drive) else $error("pulse at zero duty");
  a_ss_rise: assert property (soft_start_level >=
    $past(soft_start_level)) else $error("soft start fell");
endmodule // clamp_pwm_properties
bind clamp_pwm_timing clamp_pwm_properties chk (.clk(clk), .rst_n(rst_n),
  .ext_timebase(ext_timebase), .feedback_level(feedback_level),
  .main_drive(main_drive), .clamp_drive(clamp_drive),
  .ramp_charging(ramp_charging), .soft_start_level(soft_start_level));

// ---- testbench/sync_source.sv ----
// external sync clock source facing the timebase pin
`timescale 1ns/10ps
module sync_source (
  input wire clk,
  input wire run,
  input wire hold,
  input wire [9:0] period,
  output reg ext_timebase
);
  reg [9:0] cnt;
  initial begin
    cnt = 10'h0;
    ext_timebase = 1'b0;
  end
  // 64 ns high, well short of the discharge time
  always @(posedge clk) begin
    cnt <= (cnt + 10'h1 >= period) ? 10'h0 : cnt + 10'h1;
    ext_timebase <= hold | (run & (cnt < 10'h10));
  end
endmodule // sync_source

// ---- testbench/testbench.sv ----
// self-checking bench for the clamp pwm timing block
`timescale 1ns/10ps
module testbench;
  reg clk, rst_n, run, hold;
  reg [7:0] fb;
  reg [23:0] rc, rd, rl;
  reg [15:0] cs;
  reg [9:0] per;
  reg [31:0] sd;
  wire tb, m, c, rch;
  wire [7:0] ss;
  integer fails, checks, cyc, i, n, k;
  clamp_pwm_timing dut (.clk(clk), .rst_n(rst_n), .ext_timebase(tb),
    .feedback_level(fb), .charge_timing_resistor(rc),
    .discharge_timing_resistor(rd), .turn_on_delay_resistor(rl),
    .soft_start_capacitor(cs), .main_drive(m), .clamp_drive(c),
    .ramp_charging(rch), .soft_start_level(ss));
  sync_source src (.clk(clk), .run(run), .hold(hold), .period(per),
    .ext_timebase(tb));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function integer e_chg(input [23:0] r);
    e_chg = (r * 612) >> 16;
  endfunction
  function integer e_dis(input [23:0] r);
    e_dis = (r * 262) >> 16;
  endfunction
  function integer e_del(input [23:0] r);
    e_del = 14 + ((r * 188) >> 16);
  endfunction
  // codes after t cycles, cycles per code kept in thousandths
  function integer e_ss(input integer t);
    e_ss = t * 1000 / ((cs * rc * 456) / 100000);
  endfunction
  task chk_cnt(input [8*8:1] nm, input integer e, g, t);
    begin
      checks = checks + 1;
      if (((g >= e - t) && (g <= e + t)) !== 1'b1) begin
        fails = fails + 1;
        $display("[ERR] %0s exp %0d got %0d", nm, e, g);
      end
    end
  endtask
  task chk_code(input [8*8:1] nm, input [7:0] e, g, input integer t);
    begin
      checks = checks + 1;
      if (((g + t >= e) && (g <= e + t)) !== 1'b1) begin
        fails = fails + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task span(input l, output integer len);
    begin
      len = 0;
      while (rch !== l) @(negedge clk);
      while (rch === l) begin
        len = len + 1;
        @(negedge clk);
      end
    end
  endtask
  task tally;
    begin
      n = 0;
      repeat (300) begin
        @(negedge clk);
        n = n + m + c;
      end
    end
  endtask
  task close_out;
    begin
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      close_out;
    end
  end
  initial begin
    {rst_n, run, hold} = 3'h0;
    fb = 8'hff;
    cs = 16'h0064;
    rc = 24'h002ee0;
    rd = 24'h001770;
    rl = 24'h0;
    per = 10'h0;
    sd = 32'h58;
    fails = 0;
    checks = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (300) @(negedge clk);
    chk_code("ss_ramp", e_ss(300), ss, 4);
    repeat (1500) @(negedge clk);
    chk_code("ss_top", 8'hff, ss, 0);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk);
      sd = xs(sd);
      rc <= 24'h1f40 + sd[12:0];
      rd <= 24'h1388 + sd[24:13];
      rl <= {14'h0, sd[31:22]};
      fb <= 8'hc0 + sd[5:0];
      span(1, n);
      span(0, n);
      span(1, n);
      chk_cnt("charge", e_chg(rc), n, 2);
      span(0, n);
      chk_cnt("dischg", e_dis(rd), n, 2);
      while (m !== 1'b1) @(negedge clk);
      while (m === 1'b1) @(negedge clk);
      for (n = 0; c !== 1'b1; n = n + 1) @(negedge clk);
      chk_cnt("dead", e_del(rl), n, 1);
    end
    @(posedge clk);
    per <= e_chg(rc) + e_dis(rd) - 20;
    run <= 1'b1;
    span(1, n);
    span(0, n);
    span(1, k);
    span(0, n);
    chk_cnt("sync_dis", e_dis(rd), n, 2);
    chk_cnt("sync_per", per, k + n, 1);
    @(posedge clk);
    run <= 1'b0;
    fb <= 8'h30;
    repeat (250) @(negedge clk);
    tally;
    chk_cnt("skip", 0, n, 0);
    @(posedge clk);
    fb <= 8'hff;
    hold <= 1'b1;
    repeat (100) @(negedge clk);
    tally;
    chk_cnt("held", 0, n, 0);
    close_out;
  end
endmodule // testbench
